/* File: twi_status_pkg.sv */
// Constants, field layouts and carriers for the two-wire status and clock block.
// Assumes a CPU that reaches the status/control and clock-select registers by strobes.
package twi_status_pkg;

    // Status/control bit positions
    localparam int S1_MST = 7;
    localparam int S1_TRX = 6;
    localparam int S1_BB = 5;
    localparam int S1_PIN = 4;
    localparam int S1_ESO = 3;
    localparam int S1_BC_MSB = 2;

    // Clock-select field positions
    localparam int S2_CODE_MSB = 4;
    localparam int S2_ASC = 5;
    localparam int S2_ACK = 6;

    // Special command values
    localparam logic [7:0] S1_NOISE_CLEAR = 8'h18;

    // Reset values
    localparam logic [4:0] CODE_RESET = 5'h00;
    localparam logic [2:0] BC_RESET = 3'h0;

    localparam int DIV_W = 13;

    typedef struct packed {
        logic byte_done;
        logic addr_valid;
        logic addr_rw;
        logic addr_sent_rw;
        logic first_byte;
        logic arb_lost;
        logic last_bit;
        logic general_call;
    } xfer_event_t;

    typedef struct packed {
        logic start;
        logic stop;
    } bus_cond_t;

    // Divisor for each clock code; zero marks a forbidden code
    function automatic logic [DIV_W-1:0] divisor_of(input logic [4:0] code);
        logic [DIV_W-1:0] d;
        d = 13'h0000;
        unique case (code)
            5'h00: d = 13'h0000;
            5'h01: d = 13'h0027;
            5'h02: d = 13'h002D;
            5'h03: d = 13'h0033;
            5'h04: d = 13'h003F;
            5'h05: d = 13'h004B;
            5'h06: d = 13'h0057;
            5'h07: d = 13'h0063;
            5'h08: d = 13'h007B;
            5'h09: d = 13'h0093;
            5'h0A: d = 13'h00AB;
            5'h0B: d = 13'h00C3;
            5'h0C: d = 13'h00F3;
            5'h0D: d = 13'h0123;
            5'h0E: d = 13'h0153;
            5'h0F: d = 13'h0183;
            5'h10: d = 13'h01E3;
            5'h11: d = 13'h0243;
            5'h12: d = 13'h02A3;
            5'h13: d = 13'h0303;
            5'h14: d = 13'h03C3;
            5'h15: d = 13'h0483;
            5'h16: d = 13'h0543;
            5'h17: d = 13'h0603;
            5'h18: d = 13'h0783;
            5'h19: d = 13'h0903;
            5'h1A: d = 13'h0A83;
            5'h1B: d = 13'h0C03;
            5'h1C: d = 13'h0F03;
            5'h1D: d = 13'h1203;
            5'h1E: d = 13'h1503;
            5'h1F: d = 13'h1803;
        endcase
        return d;
    endfunction

endpackage

/* File: twi_bus_cond.sv */
// Synchronises the bus clock and data pins and finds start and stop conditions.
// Assumes raw pin levels from outside the clock domain.
`timescale 1ns/1ps
module twi_bus_cond
    import twi_status_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_scl,
    input wire logic i_sda,
    output bus_cond_t o_cond
);
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic sda_prev;
    bus_cond_t next_cond;

    always_comb begin
        next_cond.start = scl_sync[1] && sda_prev && !sda_sync[1];
        next_cond.stop = scl_sync[1] && !sda_prev && sda_sync[1];
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            sda_prev <= 1'b1;
            o_cond <= '0;
        end else begin
            scl_sync <= {scl_sync[0], i_scl};
            sda_sync <= {sda_sync[0], i_sda};
            sda_prev <= sda_sync[1];
            o_cond <= next_cond;
        end
    end
endmodule

/* File: twi_clk_div.sv */
// Bus clock generator: divides the core clock by the selected divisor.
// Assumes the code and symmetry option are stable while running.
`timescale 1ns/1ps
module twi_clk_div
    import twi_status_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_run,
    input wire logic [4:0] i_code,
    input wire logic i_asym,
    output logic o_scl_high
);
    logic [DIV_W-1:0] count;
    logic [DIV_W-1:0] next_count;
    logic next_high;
    logic [DIV_W-1:0] div;
    logic [DIV_W-1:0] low_len;

    always_comb begin
        div = divisor_of(i_code);
        low_len = i_asym ? (div >> 2) : (div >> 1);
        next_count = count;
        next_high = 1'b1;
        if (i_run && div != 13'h0000) begin
            next_count = (count >= div - 13'h0001) ? 13'h0000 : count + 13'h0001;
            next_high = next_count >= low_len;
        end else begin
            next_count = 13'h0000;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            count <= '0;
            o_scl_high <= 1'b1;
        end else begin
            count <= next_count;
            o_scl_high <= next_high;
        end
    end
endmodule

/* File: twi_status_ctrl.sv */
// Status/control and clock-select registers of the two-wire interface.
// Assumes a shift engine that reports byte, address and arbitration events.
`timescale 1ns/1ps
module twi_status_ctrl
    import twi_status_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_s1_wr,
    input wire logic i_s2_wr,
    input wire logic i_s0_access,
    input wire logic [7:0] i_wdata,
    input wire logic i_always_selected,
    input xfer_event_t i_evt,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic [7:0] o_s1_rdata,
    output logic o_scl_out,
    output logic o_scl_oe,
    output logic o_start_gen,
    output logic o_stop_gen,
    output logic o_interface_enable,
    output logic [2:0] o_bit_count,
    output logic o_ack_enable
);
    logic master_select, transmit_select, bus_busy_flag, pin_n;
    logic interface_enable, arbitration_lost_flag, addressed_as_slave_flag;
    logic general_call_flag, last_bit_flag, slave_active, arb_pend;
    logic [2:0] bit_count;
    logic [4:0] clock_divisor_code;
    logic asym, ack_en;
    logic next_mst, next_trx, next_bb, next_pin_n, next_eso, next_al, next_aas;
    logic next_ad0, next_lrb, next_slave_active, next_arb_pend;
    logic [2:0] next_bc;
    logic [4:0] next_code;
    logic next_asym, next_ack;
    logic next_start, next_stop, next_scl_oe;
    logic cancel, wr_ok, noise_clear;
    bus_cond_t cond;
    logic scl_high;

    twi_bus_cond u_cond (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_scl(i_scl),
        .i_sda(i_sda),
        .o_cond(cond)
    );

    twi_clk_div u_div (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_run(interface_enable && master_select && pin_n),
        .i_code(clock_divisor_code),
        .i_asym(asym),
        .o_scl_high(scl_high)
    );

    always_comb begin
        next_mst = master_select;
        next_trx = transmit_select;
        next_bb = bus_busy_flag;
        next_pin_n = pin_n;
        next_eso = interface_enable;
        next_al = arbitration_lost_flag;
        next_aas = addressed_as_slave_flag;
        next_ad0 = general_call_flag;
        next_lrb = last_bit_flag;
        next_slave_active = slave_active;
        next_arb_pend = arb_pend;
        next_bc = bit_count;
        next_code = clock_divisor_code;
        next_asym = asym;
        next_ack = ack_en;
        next_start = 1'b0;
        next_stop = 1'b0;
        cancel = 1'b0;
        noise_clear = i_s1_wr && bus_busy_flag && !master_select && !addressed_as_slave_flag
            && i_wdata == S1_NOISE_CLEAR;
        wr_ok = i_s1_wr && (!bus_busy_flag || master_select || addressed_as_slave_flag);
        if (i_s2_wr) begin
            next_code = i_wdata[S2_CODE_MSB:0];
            next_asym = i_wdata[S2_ASC];
            next_ack = i_wdata[S2_ACK];
        end
        if (i_s1_wr) begin
            next_eso = i_wdata[S1_ESO];
        end
        if (noise_clear) begin
            next_bb = 1'b0;
        end
        if (wr_ok && i_wdata[S1_ESO]) begin
            next_bc = i_wdata[S1_BC_MSB:0];
            cancel = i_wdata[S1_PIN];
            if (i_wdata[S1_BB] && i_wdata[S1_MST]) begin
                if (bus_busy_flag && !master_select) begin
                    next_al = 1'b1;
                    next_arb_pend = 1'b1;
                    next_mst = 1'b0;
                    next_trx = 1'b0;
                end else begin
                    next_start = 1'b1;
                    next_mst = 1'b1;
                    next_trx = i_wdata[S1_TRX];
                end
            end else if (!i_wdata[S1_BB] && master_select) begin
                next_stop = 1'b1;
                next_mst = 1'b0;
                next_trx = 1'b0;
            end else begin
                next_mst = i_wdata[S1_MST];
                next_trx = i_wdata[S1_TRX];
            end
        end
        if (i_s0_access && interface_enable) begin
            cancel = 1'b1;
        end
        if (cancel) begin
            next_pin_n = 1'b1;
            next_al = 1'b0;
            next_aas = 1'b0;
        end
        if (i_s1_wr && i_wdata[S1_ESO] && i_wdata[S1_BB] && i_wdata[S1_MST] && bus_busy_flag && !master_select) begin
            next_al = 1'b1;
            next_arb_pend = 1'b1;
            next_mst = 1'b0;
            next_trx = 1'b0;
        end
        if (interface_enable) begin
            if (cond.start) begin
                next_bb = 1'b1;
                next_ad0 = 1'b0;
                next_slave_active = 1'b0;
            end
            if (cond.stop) begin
                next_bb = 1'b0;
                next_ad0 = 1'b0;
                next_slave_active = 1'b0;
            end
            if (i_evt.arb_lost && master_select) begin
                next_al = 1'b1;
                next_arb_pend = 1'b1;
                next_mst = 1'b0;
                next_trx = 1'b0;
            end
            if (i_evt.addr_valid && !master_select && !i_always_selected) begin
                next_aas = 1'b1;
                next_slave_active = 1'b1;
                next_pin_n = 1'b0;
                if (i_evt.addr_rw) begin
                    next_trx = 1'b1;
                end
            end
            if (i_evt.general_call) begin
                next_ad0 = 1'b1;
            end
            if (i_evt.first_byte && i_always_selected && !master_select) begin
                next_aas = 1'b1;
            end
            if (i_evt.addr_sent_rw && master_select && !i_always_selected) begin
                next_trx = 1'b0;
            end
            if (i_evt.byte_done) begin
                next_lrb = i_evt.last_bit;
                if (master_select || i_always_selected || slave_active || arb_pend) begin
                    next_pin_n = 1'b0;
                    next_arb_pend = 1'b0;
                end
            end
        end
        next_scl_oe = next_eso && (!next_pin_n || (next_mst && !scl_high));
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            master_select <= 1'b0;
            transmit_select <= 1'b0;
            bus_busy_flag <= 1'b0;
            pin_n <= 1'b1;
            interface_enable <= 1'b0;
            arbitration_lost_flag <= 1'b0;
            addressed_as_slave_flag <= 1'b0;
            general_call_flag <= 1'b0;
            last_bit_flag <= 1'b0;
            slave_active <= 1'b0;
            arb_pend <= 1'b0;
            bit_count <= BC_RESET;
            clock_divisor_code <= CODE_RESET;
            asym <= 1'b0;
            ack_en <= 1'b0;
            o_start_gen <= 1'b0;
            o_stop_gen <= 1'b0;
            o_scl_oe <= 1'b0;
            o_s1_rdata <= 8'h10;
        end else begin
            master_select <= next_mst;
            transmit_select <= next_trx;
            bus_busy_flag <= next_bb;
            pin_n <= next_pin_n;
            interface_enable <= next_eso;
            arbitration_lost_flag <= next_al;
            addressed_as_slave_flag <= next_aas;
            general_call_flag <= next_ad0;
            last_bit_flag <= next_lrb;
            slave_active <= next_slave_active;
            arb_pend <= next_arb_pend;
            bit_count <= next_bc;
            clock_divisor_code <= next_code;
            asym <= next_asym;
            ack_en <= next_ack;
            o_start_gen <= next_start;
            o_stop_gen <= next_stop;
            o_scl_oe <= next_scl_oe;
            o_s1_rdata <= {next_mst, next_trx, next_bb, next_pin_n, next_al, next_aas, next_ad0, next_lrb};
        end
    end

    assign o_scl_out = 1'b0;
    assign o_interface_enable = interface_enable;
    assign o_bit_count = bit_count;
    assign o_ack_enable = ack_en;

    chk_stop_clears_roles: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_s1_wr && i_wdata == 8'hD8 && master_select) |=> (o_stop_gen && !master_select && !transmit_select))
        else $error("stop write did not clear roles");
    chk_slave_turns_tx: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (interface_enable && i_evt.addr_valid && i_evt.addr_rw && !master_select && !i_always_selected)
        |=> transmit_select && !pin_n)
        else $error("slave did not become transmitter");
    chk_master_turns_rx: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (interface_enable && i_evt.addr_sent_rw && master_select && !i_always_selected && !i_evt.arb_lost
        && !i_s1_wr) |=> !transmit_select)
        else $error("master did not become receiver");
    chk_byte_interrupt: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (interface_enable && i_evt.byte_done && (master_select || i_always_selected)) |=> !pin_n)
        else $error("no interrupt after byte");
    chk_stretch_low: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (!pin_n && interface_enable) |-> o_scl_oe)
        else $error("clock not held low while pending");
    chk_data_cancel: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_s0_access && interface_enable && !i_evt.byte_done && !i_evt.addr_valid && !i_evt.arb_lost && !i_s1_wr)
        |=> pin_n && !arbitration_lost_flag)
        else $error("data access did not cancel");
    chk_busy_inhibit: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_s1_wr && bus_busy_flag && !master_select && !addressed_as_slave_flag && !i_evt.arb_lost)
        |=> $stable(transmit_select) || $past(i_evt.addr_valid, 1))
        else $error("write accepted on busy bus");
    chk_noise_clear: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_s1_wr && i_wdata == 8'h18 && bus_busy_flag && !master_select && !addressed_as_slave_flag
        && !cond.start) |=> !bus_busy_flag)
        else $error("noise clear write failed");
    chk_busy_start_lost: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_s1_wr && i_wdata[S1_ESO] && i_wdata[S1_BB] && i_wdata[S1_MST] && bus_busy_flag && !master_select
        ) |=> arbitration_lost_flag && !master_select && !o_start_gen)
        else $error("start on busy bus not refused");
    chk_arb_lost: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (interface_enable && i_evt.arb_lost && master_select) |=> arbitration_lost_flag && !master_select)
        else $error("arbitration loss not taken");

    cov_master_stop: cover property (@(posedge i_core_clk) disable iff (i_rst) o_start_gen ##[1:300] o_stop_gen);
    cov_slave_tx: cover property (@(posedge i_core_clk) disable iff (i_rst)
        addressed_as_slave_flag && transmit_select);
    cov_arb_irq: cover property (@(posedge i_core_clk) disable iff (i_rst)
        arbitration_lost_flag && !pin_n);
endmodule

/* File: bus_partner_model.sv */
// Far-side bus party: another master that makes start and stop conditions.
// Assumes open-drain lines with pull-ups; the block under test only pulls the clock.
`timescale 1ns/1ps
module bus_partner_model (
    input wire logic i_core_clk,
    input wire logic i_scl_oe,
    output logic o_scl,
    output logic o_sda
);
    logic scl_low = 1'b0;
    logic sda_low = 1'b0;

    // Wired-AND lines, pulled high when released
    assign o_scl = ~(scl_low | i_scl_oe);
    assign o_sda = ~sda_low;

    task automatic hold(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask

    // start: data falls while clock high
    task automatic make_start(input int gap);
        hold(1);
        scl_low <= 1'b0;
        sda_low <= 1'b0;
        hold(gap);
        sda_low <= 1'b1;
        hold(gap);
        scl_low <= 1'b1;
        hold(gap);
    endtask

    // stop: data rises while clock high
    task automatic make_stop(input int gap);
        hold(1);
        scl_low <= 1'b1;
        hold(gap);
        sda_low <= 1'b1;
        hold(gap);
        scl_low <= 1'b0;
        hold(gap);
        sda_low <= 1'b0;
        hold(gap);
    endtask
endmodule

/* File: testbench.sv */
// Self-checking bench for the two-wire status/control and clock-select block.
// Assumes the bus partner model; events are driven in place of a shift engine.
`timescale 1ns/1ps
module testbench;
    import twi_status_pkg::*;

    localparam logic [7:0] EV_DONE = 8'h80;
    localparam logic [7:0] EV_AVAL = 8'h40;
    localparam logic [7:0] EV_ARW = 8'h20;
    localparam logic [7:0] EV_SRW = 8'h10;
    localparam logic [7:0] EV_FIRST = 8'h08;

    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_s1_wr = 1'b0;
    logic i_s2_wr = 1'b0;
    logic i_s0_access = 1'b0;
    logic [7:0] i_wdata = 8'h00;
    logic i_always_selected = 1'b0;
    xfer_event_t i_evt = '0;
    logic scl;
    logic sda;
    logic [7:0] s1;
    logic scl_oe;
    logic scl_out;
    logic start_gen;
    logic stop_gen;
    logic ie;
    logic ack;
    logic [2:0] bc;
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;

    twi_status_ctrl dut_u (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_s1_wr(i_s1_wr),
        .i_s2_wr(i_s2_wr),
        .i_s0_access(i_s0_access),
        .i_wdata(i_wdata),
        .i_always_selected(i_always_selected),
        .i_evt(i_evt),
        .i_scl(scl),
        .i_sda(sda),
        .o_s1_rdata(s1),
        .o_scl_out(scl_out),
        .o_scl_oe(scl_oe),
        .o_start_gen(start_gen),
        .o_stop_gen(stop_gen),
        .o_interface_enable(ie),
        .o_bit_count(bc),
        .o_ack_enable(ack)
    );

    bus_partner_model partner_u (
        .i_core_clk(i_core_clk),
        .i_scl_oe(scl_oe),
        .o_scl(scl),
        .o_sda(sda)
    );

    initial begin
        forever #2.5 i_core_clk = ~i_core_clk;
    end

    always @(posedge i_core_clk) begin
        cycles = cycles + 1;
        if (cycles > 40000) begin
            errors = errors + 1;
            summarize();
        end
    end

    task automatic summarize();
        if (errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g, input logic [7:0] m);
        num_checks++;
        if ((g & m) !== (e & m)) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e & m, g & m);
        end
    endtask

    task automatic chk_bit(input string n, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic chk_num(input string n, input int e, input int g);
        num_checks++;
        if (g != e) begin
            errors++;
            $display("wrong value %s expected %0d seen %0d", n, e, g);
        end
    endtask

    task automatic wr(input logic sel2, input logic [7:0] d);
        @(posedge i_core_clk);
        i_wdata <= d;
        i_s1_wr <= ~sel2;
        i_s2_wr <= sel2;
        @(posedge i_core_clk);
        i_s1_wr <= 1'b0;
        i_s2_wr <= 1'b0;
        #1;
    endtask

    task automatic ev(input logic [7:0] v);
        @(posedge i_core_clk);
        i_evt <= xfer_event_t'(v);
        @(posedge i_core_clk);
        i_evt <= '0;
        #1;
    endtask

    task automatic s0_touch();
        @(posedge i_core_clk);
        i_s0_access <= 1'b1;
        @(posedge i_core_clk);
        i_s0_access <= 1'b0;
        #1;
    endtask

    task automatic settle();
        repeat (2) @(posedge i_core_clk);
        #1;
    endtask

    // Cycles from now to the next rising edge of the clock pull
    task automatic rise(output int n);
        logic p;
        n = 0;
        p = scl_oe;
        @(posedge i_core_clk);
        #1;
        n = 1;
        while (!(scl_oe && !p)) begin
            p = scl_oe;
            @(posedge i_core_clk);
            #1;
            n++;
        end
    endtask

    task automatic period(input logic [4:0] code, input logic asym, input int d);
        int n;
        wr(1'b1, {2'b01, asym, code});
        rise(n);
        rise(n);
        rise(n);
        chk_num("divisor", d, n);
    endtask

    task automatic t_reset();
        settle();
        chk("s1", 8'h10, s1, 8'hFF);
        chk_bit("clock out", 1'b0, scl_out);
    endtask

    task automatic t_enable();
        wr(1'b0, 8'hF0);
        settle();
        chk("s1", 8'h10, s1, 8'hFF);
        chk_bit("enable", 1'b0, ie);
        wr(1'b0, 8'h0B);
        settle();
        chk_bit("enable", 1'b1, ie);
        chk("count", 8'h03, {5'h00, bc}, 8'hFF);
        chk("s1", 8'h00, s1, 8'h0F);
    endtask

    task automatic t_master();
        wr(1'b0, 8'hF8);
        chk_bit("start", 1'b1, start_gen);
        settle();
        chk("s1", 8'hC0, s1, 8'hC0);
        period(5'h01, 1'b0, 39);
        chk_bit("ack", 1'b1, ack);
        period(5'h02, 1'b0, 45);
        period(5'h04, 1'b1, 63);
        period(5'h1F, 1'b0, 6147);
        wr(1'b1, 8'h40);
        repeat (40) @(posedge i_core_clk);
        #1;
        chk_bit("clock pull", 1'b0, scl_oe);
        ev(EV_DONE | EV_SRW);
        settle();
        chk("s1", 8'h80, s1, 8'hD0);
        chk_bit("clock pull", 1'b1, scl_oe);
        s0_touch();
        settle();
        chk("s1", 8'h10, s1, 8'h10);
        wr(1'b0, 8'hD8);
        chk_bit("stop", 1'b1, stop_gen);
        settle();
        chk("s1", 8'h00, s1, 8'hC0);
    endtask

    task automatic t_lost();
        partner_u.make_start(4);
        repeat (6) @(posedge i_core_clk);
        #1;
        chk("s1", 8'h20, s1, 8'h20);
        wr(1'b0, 8'hF8);
        chk_bit("start", 1'b0, start_gen);
        settle();
        chk("s1", 8'h28, s1, 8'hE8);
        ev(EV_DONE);
        settle();
        chk("s1", 8'h08, s1, 8'h18);
        wr(1'b0, 8'h38);
        settle();
        chk("s1", 8'h00, s1, 8'h10);
        s0_touch();
        settle();
        chk("s1", 8'h10, s1, 8'h18);
        wr(1'b0, 8'h18);
        settle();
        chk("s1", 8'h00, s1, 8'h20);
        wr(1'b0, 8'h18);
        settle();
        chk("s1", 8'h10, s1, 8'hF0);
        partner_u.make_stop(2);
    endtask

    task automatic t_slave();
        partner_u.make_start(9);
        ev(EV_AVAL | EV_ARW);
        settle();
        chk("s1", 8'h64, s1, 8'hF4);
        chk_bit("clock pull", 1'b1, scl_oe);
        wr(1'b0, 8'h38);
        settle();
        chk("s1", 8'h30, s1, 8'hF4);
        chk_bit("clock pull", 1'b0, scl_oe);
        partner_u.make_stop(9);
        settle();
        chk("s1", 8'h00, s1, 8'h20);
    endtask

    task automatic t_always();
        @(posedge i_core_clk);
        i_always_selected <= 1'b1;
        ev(EV_DONE | EV_FIRST);
        settle();
        chk("s1", 8'h04, s1, 8'h14);
        wr(1'b0, 8'h19);
        settle();
        chk("s1", 8'h10, s1, 8'h14);
        chk("count", 8'h01, {5'h00, bc}, 8'hFF);
        @(posedge i_core_clk);
        i_always_selected <= 1'b0;
    endtask

    initial begin
        repeat (16) @(posedge i_core_clk);
        i_rst <= 1'b0;
        t_reset();
        t_enable();
        t_master();
        t_lost();
        t_slave();
        t_always();
        summarize();
    end
endmodule
